/* inc/sfb_defines.svh */
// Constants of the signal function blocks: offsets, reset values, timing.
`ifndef SFB_DEFINES_SVH
`define SFB_DEFINES_SVH

// ===============================================
// Register byte offsets
`define SFB_SAVE_OFS    12'h004
`define SFB_STAT_OFS    12'h008
`define SFB_LIM1_HI_OFS 12'h010
`define SFB_LIM1_LO_OFS 12'h014
`define SFB_LIM1_IN_OFS 12'h018
`define SFB_LIM2_HI_OFS 12'h01c
`define SFB_LIM2_LO_OFS 12'h020
`define SFB_LIM2_IN_OFS 12'h024
`define SFB_LAG_TC_OFS  12'h028
`define SFB_LAG_IN_OFS  12'h02c
`define SFB_ADD_OP_OFS  12'h030
`define SFB_SQ_HI_OFS   12'h048
`define SFB_SQ_LO_OFS   12'h04c
`define SFB_SQ_TIME_OFS 12'h050
`define SFB_ABS_IN_OFS  12'h054
`define SFB_IN_SEL_OFS  12'h060
`define SFB_TGT_SEL_OFS 12'h0a0
`define SFB_OUT_OFS     12'h0e0

// ===============================================
// Reset values and saturation bounds (100% = 16'h4000)
`define SFB_PLUS100     16'sh4000
`define SFB_MINUS100    16'shc000
`define SFB_SAT_MAX     16'sh7fff
`define SFB_SAT_MIN     16'sh8000
`define SFB_LAG_TC_RST  13'h07d0
`define SFB_LAG_TC_MAX  13'h1388
`define SFB_SQ_TIME_RST 15'h0001
`define SFB_SQ_TIME_MAX 15'h7530

// ===============================================
// Timing: sample tick period and parameter units, in microseconds
`define SFB_TICK_US     1000
`define SFB_LAG_UNIT_US 10000
`define SFB_SQ_UNIT_US  100000
`define SFB_LAG_TICKS   (`SFB_LAG_UNIT_US / `SFB_TICK_US)
`define SFB_SQ_TICKS    (`SFB_SQ_UNIT_US / `SFB_TICK_US)

// ===============================================
// Sizes
`define SFB_NSRC        8
`define SFB_NTGT        4

`endif

/* inc/sfb_pkg.sv */
// Types shared by the signal function blocks.
package sfb_pkg;

    // ===============================================
    // Signal sample: signed, full scale is plus or minus 200 percent.
    typedef logic signed [15:0] sfb_sample_t;

    // Source or target selector code.
    typedef logic [4:0] sfb_sel_t;

    // APB request as driven by the bus master.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sfb_apb_req_t;

    // APB answer of the slave.
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sfb_apb_rsp_t;

endpackage

/* design/sfb_top.sv */
// Signal function blocks: absolute value, limiters, lag, adders, square wave.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sfb_defines.svh"

module sfb_top #(
    parameter int          NSRC          = `SFB_NSRC,      // External source count.
    parameter int          NTGT          = `SFB_NTGT,      // Target count.
    parameter int unsigned LAG_TICKS     = `SFB_LAG_TICKS, // Ticks per 0.01 s.
    parameter int unsigned SQ_TICKS      = `SFB_SQ_TICKS   // Ticks per 0.1 s.
) (
    input  wire logic                             pclk,        // Bus and block clock.
    input  wire logic                             presetn,     // Asynchronous reset, active low.
    input  wire logic                             ce,          // Clock enable, freezes all state.
    input  wire logic                             sample_tick, // One-cycle sample pulse.
    input  wire sfb_pkg::sfb_apb_req_t            apb_req,     // APB request.
    input  wire sfb_pkg::sfb_sample_t [NSRC-1:0]  src_in,      // External terminal signals.
    output sfb_pkg::sfb_apb_rsp_t                 apb_rsp,     // APB answer.
    output sfb_pkg::sfb_sample_t [NTGT-1:0]       tgt_out,     // Routed target signals.
    output logic                                  save_req     // Pulse asking to store settings.
);
    import sfb_pkg::*;

    // ===============================================
    // Local sizes and state
    localparam int NIN = 10;  // Block inputs: abs, lim1, lim2, lag, 3 per adder.
    localparam int NOUT = 7;  // Block outputs: abs, lim1, lim2, lag, add1, add2, square.

    // All state of the block in one word.
    typedef struct packed {
        sfb_apb_rsp_t                   rsp;
        logic                           save;
        sfb_sel_t    [NIN-1:0]          in_sel;
        sfb_sel_t    [NTGT-1:0]         tgt_sel;
        sfb_sample_t [5:0]              op;
        sfb_sample_t                    lim1_hi;
        sfb_sample_t                    lim1_lo;
        sfb_sample_t                    lim2_hi;
        sfb_sample_t                    lim2_lo;
        sfb_sample_t                    sq_hi;
        sfb_sample_t                    sq_lo;
        logic        [12:0]             lag_tc;
        logic        [14:0]             sq_time;
        logic signed [31:0]             lag_acc;
        logic        [31:0]             sq_cnt;
        logic                           sq_phase;
        sfb_sample_t [NOUT-1:0]         outs;
        sfb_sample_t [NTGT-1:0]         tgt;
    } sfb_state_t;

    sfb_state_t s_q;  // Registered state.
    sfb_state_t s_d;  // Next state.

    // ===============================================
    // Helper functions

    // Clamp a wide signed value into the sample range.
    function automatic sfb_sample_t sat(input logic signed [33:0] v);
        if (v > 34'(`SFB_SAT_MAX)) begin
            sat = `SFB_SAT_MAX;
        end else if (v < 34'(`SFB_SAT_MIN)) begin
            sat = `SFB_SAT_MIN;
        end else begin
            sat = v[15:0];
        end
    endfunction

    // Select a signal: 0 none, 1..7 block outputs, then external sources.
    function automatic sfb_sample_t pick(input sfb_sel_t code,
                                         input sfb_sample_t [NOUT-1:0] o,
                                         input sfb_sample_t [NSRC-1:0] e);
        pick = '0;
        if (code != '0 && int'(code) <= NOUT) begin
            pick = o[int'(code) - 1];
        end else if (int'(code) > NOUT && int'(code) <= NOUT + NSRC) begin
            pick = e[int'(code) - NOUT - 1];
        end
    endfunction

    // ===============================================
    // Live block inputs
    sfb_sample_t [NIN-1:0] live;  // Selected source per block input.
    sfb_sample_t [5:0]     opv;   // Effective adder operands.

    // Each block input reads its own selected source.
    for (genvar i = 0; i < NIN; i++) begin : g_in
        assign live[i] = pick(s_q.in_sel[i], s_q.outs, src_in);
    end

    // A routed operand follows the source; otherwise the constant applies.
    for (genvar k = 0; k < 6; k++) begin : g_op
        assign opv[k] = (s_q.in_sel[4+k] != '0) ? live[4+k] : s_q.op[k];
    end

    // ===============================================
    // Block arithmetic, evaluated every cycle, taken on a sample tick
    sfb_sample_t        abs_v;     // Absolute value.
    sfb_sample_t        lim1_v;    // Limiter 1 result.
    sfb_sample_t        lim2_v;    // Limiter 2 result.
    sfb_sample_t        add1_v;    // Adder 1 result.
    sfb_sample_t        add2_v;    // Adder 2 result.
    logic        [31:0] lag_n;     // Lag divisor in ticks.
    logic signed [32:0] lag_diff;  // Input minus filter state, 16.16.
    logic signed [32:0] lag_step;  // Per-tick correction.
    logic        [31:0] sq_limit;  // Ticks per level.
    logic signed [31:0] lag_rnd;   // Rounded filter state.

    // The most negative code has no positive twin, so it saturates.
    assign abs_v = sat(live[0][15] ? -34'(live[0]) : 34'(live[0]));

    // Upper limit wins above, lower limit below, else the input passes.
    assign lim1_v = (live[1] > s_q.lim1_hi) ? s_q.lim1_hi :
                    (live[1] < s_q.lim1_lo) ? s_q.lim1_lo : live[1];
    assign lim2_v = (live[2] > s_q.lim2_hi) ? s_q.lim2_hi :
                    (live[2] < s_q.lim2_lo) ? s_q.lim2_lo : live[2];

    // Sum of first two operands minus the third, clamped to 200 percent.
    assign add1_v = sat(34'(opv[0]) + 34'(opv[1]) - 34'(opv[2]));
    assign add2_v = sat(34'(opv[3]) + 34'(opv[4]) - 34'(opv[5]));

    // Lag: y += (x - y) / N with N = T / tick; the fraction keeps gain one.
    assign lag_n    = 32'(s_q.lag_tc) * 32'(LAG_TICKS);
    // The concatenation is unsigned, so it is made signed before widening; negative inputs stay negative.
    assign lag_diff = 33'($signed({live[3], 16'h0000})) - 33'(s_q.lag_acc);
    assign lag_step = lag_diff / $signed({1'b0, lag_n});
    // Round the updated state, so a tick's output already carries that tick's step.
    assign lag_rnd  = s_q.lag_acc + lag_step[31:0] + 32'sh0000_8000;

    // Each level holds for the switch time counted in sample ticks.
    assign sq_limit = 32'(s_q.sq_time) * 32'(SQ_TICKS);

    // ===============================================
    // Register read mux
    logic [11:0] a;      // Word address of the access.
    logic [31:0] rdata;  // Read value.
    logic        hit;    // Address is mapped.

    assign a = {apb_req.paddr[11:2], 2'b00};

    // Decode reads; unmapped addresses answer zero with an error.
    always_comb begin
        rdata = '0;
        hit   = 1'b1;
        case (a)
            `SFB_SAVE_OFS:    rdata = '0;
            `SFB_STAT_OFS:    rdata = {31'h0, s_q.sq_phase};
            `SFB_LIM1_HI_OFS: rdata = {16'h0, s_q.lim1_hi};
            `SFB_LIM1_LO_OFS: rdata = {16'h0, s_q.lim1_lo};
            `SFB_LIM1_IN_OFS: rdata = {16'h0, live[1]};
            `SFB_LIM2_HI_OFS: rdata = {16'h0, s_q.lim2_hi};
            `SFB_LIM2_LO_OFS: rdata = {16'h0, s_q.lim2_lo};
            `SFB_LIM2_IN_OFS: rdata = {16'h0, live[2]};
            `SFB_LAG_TC_OFS:  rdata = {19'h0, s_q.lag_tc};
            `SFB_LAG_IN_OFS:  rdata = {16'h0, live[3]};
            `SFB_SQ_HI_OFS:   rdata = {16'h0, s_q.sq_hi};
            `SFB_SQ_LO_OFS:   rdata = {16'h0, s_q.sq_lo};
            `SFB_SQ_TIME_OFS: rdata = {17'h0, s_q.sq_time};
            `SFB_ABS_IN_OFS:  rdata = {16'h0, live[0]};
            default: begin
                hit = 1'b0;
                for (int k = 0; k < 6; k++) begin
                    if (a == `SFB_ADD_OP_OFS + 12'(4 * k)) begin
                        rdata = {16'h0, opv[k]};
                        hit   = 1'b1;
                    end
                end
                for (int i = 0; i < NIN; i++) begin
                    if (a == `SFB_IN_SEL_OFS + 12'(4 * i)) begin
                        rdata = {27'h0, s_q.in_sel[i]};
                        hit   = 1'b1;
                    end
                end
                for (int j = 0; j < NTGT; j++) begin
                    if (a == `SFB_TGT_SEL_OFS + 12'(4 * j)) begin
                        rdata = {27'h0, s_q.tgt_sel[j]};
                        hit   = 1'b1;
                    end
                end
                for (int o = 0; o < NOUT; o++) begin
                    if (a == `SFB_OUT_OFS + 12'(4 * o)) begin
                        rdata = {16'h0, s_q.outs[o]};
                        hit   = 1'b1;
                    end
                end
            end
        endcase
    end

    // ===============================================
    // Next state
    logic        wr;  // Write completes this edge.
    sfb_sample_t wv;  // Write data as a sample.

    // A write lands at the edge where pready is seen high.
    assign wr = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite && hit;
    assign wv = apb_req.pwdata[15:0];

    always_comb begin
        s_d      = s_q;
        s_d.save = 1'b0;
        // One wait state: pready rises in the second access cycle.
        s_d.rsp.pready = apb_req.psel && apb_req.penable && !s_q.rsp.pready;
        if (apb_req.psel && apb_req.penable && !s_q.rsp.pready) begin
            s_d.rsp.prdata  = apb_req.pwrite ? 32'h0 : rdata;
            s_d.rsp.pslverr = !hit;
        end
        if (wr) begin
            case (a)
                `SFB_SAVE_OFS:    s_d.save = apb_req.pwdata[0];
                `SFB_LIM1_HI_OFS: s_d.lim1_hi = wv;
                `SFB_LIM1_LO_OFS: s_d.lim1_lo = wv;
                `SFB_LIM2_HI_OFS: s_d.lim2_hi = wv;
                `SFB_LIM2_LO_OFS: s_d.lim2_lo = wv;
                // Out-of-range time constants are pulled into range; zero would divide by zero.
                `SFB_LAG_TC_OFS: begin
                    if (apb_req.pwdata[12:0] == '0) begin
                        s_d.lag_tc = 13'h0001;
                    end else if (apb_req.pwdata[12:0] > `SFB_LAG_TC_MAX) begin
                        s_d.lag_tc = `SFB_LAG_TC_MAX;
                    end else begin
                        s_d.lag_tc = apb_req.pwdata[12:0];
                    end
                end
                `SFB_SQ_HI_OFS:   s_d.sq_hi = wv;
                `SFB_SQ_LO_OFS:   s_d.sq_lo = wv;
                `SFB_SQ_TIME_OFS: begin
                    if (apb_req.pwdata[14:0] == '0) begin
                        s_d.sq_time = `SFB_SQ_TIME_RST;
                    end else if (apb_req.pwdata[14:0] > `SFB_SQ_TIME_MAX) begin
                        s_d.sq_time = `SFB_SQ_TIME_MAX;
                    end else begin
                        s_d.sq_time = apb_req.pwdata[14:0];
                    end
                end
                default: begin
                    for (int k = 0; k < 6; k++) begin
                        // A routed operand ignores writes.
                        if (a == `SFB_ADD_OP_OFS + 12'(4 * k) && s_q.in_sel[4+k] == '0) begin
                            s_d.op[k] = wv;
                        end
                    end
                    for (int i = 0; i < NIN; i++) begin
                        if (a == `SFB_IN_SEL_OFS + 12'(4 * i)) begin
                            s_d.in_sel[i] = apb_req.pwdata[4:0];
                        end
                    end
                    for (int j = 0; j < NTGT; j++) begin
                        if (a == `SFB_TGT_SEL_OFS + 12'(4 * j)) begin
                            s_d.tgt_sel[j] = apb_req.pwdata[4:0];
                        end
                    end
                end
            endcase
        end
        // Blocks advance once per sample tick.
        if (sample_tick) begin
            s_d.outs[0] = abs_v;
            s_d.outs[1] = lim1_v;
            s_d.outs[2] = lim2_v;
            s_d.lag_acc = s_q.lag_acc + lag_step[31:0];
            s_d.outs[3] = lag_rnd[31:16];
            s_d.outs[4] = add1_v;
            s_d.outs[5] = add2_v;
            if (s_q.sq_cnt + 32'h1 >= sq_limit) begin
                s_d.sq_cnt   = '0;
                s_d.sq_phase = !s_q.sq_phase;
            end else begin
                s_d.sq_cnt = s_q.sq_cnt + 32'h1;
            end
            s_d.outs[6] = s_q.sq_phase ? s_q.sq_lo : s_q.sq_hi;
        end
        // Targets copy the chosen block output or external source every cycle.
        for (int j = 0; j < NTGT; j++) begin
            s_d.tgt[j] = pick(s_q.tgt_sel[j], s_q.outs, src_in);
        end
    end

    // ===============================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.lim1_hi <= `SFB_PLUS100;
            s_q.lim1_lo <= `SFB_MINUS100;
            s_q.lim2_hi <= `SFB_PLUS100;
            s_q.lim2_lo <= `SFB_MINUS100;
            s_q.lag_tc  <= `SFB_LAG_TC_RST;
            s_q.sq_time <= `SFB_SQ_TIME_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign apb_rsp  = s_q.rsp;
    assign tgt_out  = s_q.tgt;
    assign save_req = s_q.save;

endmodule

/* verif/sfb_top_sva.sv */
// Port-level timing checks for the signal function blocks.
`timescale 1ns/1ps
`include "sfb_defines.svh"
module sfb_top_sva #(
    parameter int NSRC = 8, // Source count.
    parameter int NTGT = 4  // Target count.
) (
    input wire logic                            pclk,        // Clock.
    input wire logic                            presetn,     // Reset, active low.
    input wire logic                            ce,          // Clock enable.
    input wire logic                            sample_tick, // Sample pulse.
    input wire sfb_pkg::sfb_apb_req_t           apb_req,     // APB request.
    input wire sfb_pkg::sfb_sample_t [NSRC-1:0] src_in,      // Sources.
    input wire sfb_pkg::sfb_apb_rsp_t           apb_rsp,     // APB answer.
    input wire sfb_pkg::sfb_sample_t [NTGT-1:0] tgt_out,     // Targets.
    input wire logic                            save_req     // Save pulse.
);
    import sfb_pkg::*;
    // ===============================================
    // Helpers: a completed write, and a completed write of the save bit.
    logic wr_any;  // Write accepted at this edge.
    logic wr_save; // Save request accepted at this edge.
    assign wr_any  = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign wr_save = wr_any && apb_req.paddr == `SFB_SAVE_OFS && apb_req.pwdata[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ===============================================
    // Assertions.
    chk_ready_wait: assert property (
        apb_req.psel && apb_req.penable && !apb_rsp.pready && ce |=> apb_rsp.pready) else $error("pready late");
    chk_ready_pulse: assert property (
        apb_rsp.pready && ce |=> !apb_rsp.pready) else $error("pready too long");
    chk_ready_cause: assert property (
        apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable)) else $error("pready without access");
    chk_err_zero: assert property (
        apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0) else $error("error read not zero");
    chk_tgt_hold: assert property (
        !$stable(tgt_out) |-> $past(sample_tick && ce, 2) || $past(wr_any) || $past(wr_any, 2))
        else $error("target moved without tick");
    chk_ce_freeze: assert property (
        !ce |=> $stable(tgt_out) && $stable(apb_rsp)) else $error("state moved with ce low");
    chk_save_cause: assert property (
        save_req |-> $past(wr_save) || $past(wr_save, 2)) else $error("save pulse without write");
    chk_save_pulse: assert property (
        save_req && ce |=> !save_req) else $error("save pulse too long");
    // Main scenarios reached.
    cover property (wr_save);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
    cover property (sample_tick && ce);
    cover property (sample_tick && !ce);
endmodule

bind sfb_top sfb_top_sva #(.NSRC(NSRC), .NTGT(NTGT)) u_sva (.pclk(pclk), .presetn(presetn), .ce(ce),
    .sample_tick(sample_tick), .apb_req(apb_req), .src_in(src_in), .apb_rsp(apb_rsp), .tgt_out(tgt_out),
    .save_req(save_req));

/* verif/sfb_src_model.sv */
// Model of the terminal signal sources that feed the blocks.
`timescale 1ns/1ps
module sfb_src_model #(
    parameter int NSRC = 8 // Source count.
) (
    input wire logic                       pclk,        // Clock.
    input wire logic                       presetn,     // Reset, active low.
    input wire logic                       sample_tick, // Sample pulse.
    output sfb_pkg::sfb_sample_t [NSRC-1:0] src_out     // Source values.
);
    import sfb_pkg::*;
    // Fresh full-range values just after every tick, so each sample sees new data
    // and extremes near both bounds show up without a dedicated test.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_out <= '0;
        end else if (sample_tick) begin
            for (int i = 0; i < NSRC; i++) begin
                src_out[i] <= sfb_sample_t'($urandom);
            end
        end
    end
endmodule

/* verif/sfb_top_test.sv */
// Self-checking testbench of the signal function blocks.
`timescale 1ns/1ps
`include "sfb_defines.svh"
module sfb_top_test;
    import sfb_pkg::*;
    logic                 pclk, presetn, ce, tick, save_req, seen_save, re; // Bench signals.
    sfb_apb_req_t         req;       // APB request.
    sfb_apb_rsp_t         rsp;       // APB answer.
    sfb_sample_t [7:0]    src;       // Sources from the partner.
    sfb_sample_t [3:0]    tgt, t0;   // Targets and a snapshot.
    logic [31:0]          rv;        // Last read data.
    int                   n_errors, n_compared, cyc, lo[2], hi[2], op[6], s[8], prv, run, nch;
    sfb_top #(.LAG_TICKS(1), .SQ_TICKS(1)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .sample_tick(tick),
        .apb_req(req), .src_in(src), .apb_rsp(rsp), .tgt_out(tgt), .save_req(save_req));
    sfb_src_model #(.NSRC(8)) u_src (.pclk(pclk), .presetn(presetn), .sample_tick(tick), .src_out(src));
    // ===============================================
    // Reference model arithmetic, clamped to the signed 16-bit range.
    function automatic int sat(int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction
    function automatic int lim(int v, int l, int h);
        return v > h ? h : (v < l ? l : v);
    endfunction
    function automatic logic [31:0] w16(int v);
        return {16'h0000, v[15:0]};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input int w, input int a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w[0];
        req.paddr <= a[11:0];
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        // No cycle limit here: the wait ends when pready is seen high, or else at the bench timeout.
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rv = rsp.prdata; re = rsp.pslverr;
        req.psel <= 1'b0; req.penable <= 1'b0;
    endtask
    // One sample tick; source values are captured as the tick edge will see them.
    task automatic step();
        @(posedge pclk);
        tick <= 1'b1;
        for (int i = 0; i < 8; i++) s[i] = src[i];
        @(posedge pclk);
        tick <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Timeout guard and save pulse monitor.
    always @(posedge pclk) begin
        cyc++;
        if (save_req === 1'b1) seen_save <= 1'b1;
        if (cyc > 40000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        presetn = 0; ce = 1; tick = 0; req = '0; seen_save = 0; n_errors = 0; n_compared = 0; cyc = 0;
        rv = $urandom(32'h1209);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // ===============================================
        // Reset values of the settings.
        apb(0, `SFB_LIM1_HI_OFS, 0); cmp("lim1_hi", 32'h4000, rv);
        apb(0, `SFB_LIM1_LO_OFS, 0); cmp("lim1_lo", 32'hc000, rv);
        apb(0, `SFB_LIM2_LO_OFS, 0); cmp("lim2_lo", 32'hc000, rv);
        apb(0, `SFB_LAG_TC_OFS, 0); cmp("lag_tc", 32'd2000, rv);
        $display("reset values done");
        // Absolute value and both limiters fed from sources, the two limiters routed to targets.
        apb(1, `SFB_IN_SEL_OFS, 8); apb(1, `SFB_IN_SEL_OFS + 4, 9); apb(1, `SFB_IN_SEL_OFS + 8, 10);
        apb(1, `SFB_TGT_SEL_OFS, 2); apb(1, `SFB_TGT_SEL_OFS + 4, 3);
        for (int n = 0; n < 16; n++) begin
            for (int k = 0; k < 2; k++) begin
                lo[k] = int'($urandom_range(65534)) - 32768;
                hi[k] = lo[k] + 1 + int'($urandom_range(32766 - lo[k]));
                apb(1, `SFB_LIM1_HI_OFS + 12 * k, w16(hi[k])); apb(1, `SFB_LIM1_LO_OFS + 12 * k, w16(lo[k]));
            end
            step();
            apb(0, `SFB_OUT_OFS, 0); cmp("abs", w16(sat(s[0] < 0 ? -s[0] : s[0])), rv);
            apb(0, `SFB_OUT_OFS + 4, 0); cmp("lim1", w16(lim(s[1], lo[0], hi[0])), rv);
            apb(0, `SFB_OUT_OFS + 8, 0); cmp("lim2", w16(lim(s[2], lo[1], hi[1])), rv);
            cmp("tgt0", w16(lim(s[1], lo[0], hi[0])), {16'h0, tgt[0]});
            cmp("tgt1", w16(lim(s[2], lo[1], hi[1])), {16'h0, tgt[1]});
        end
        $display("limiter test done");
        // Adders with software constants, then with a routed operand.
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 6; k++) begin
                op[k] = int'($urandom_range(65535)) - 32768;
                apb(1, `SFB_ADD_OP_OFS + 4 * k, w16(op[k]));
            end
            step();
            apb(0, `SFB_OUT_OFS + 16, 0); cmp("add1", w16(sat(op[0] + op[1] - op[2])), rv);
            apb(0, `SFB_OUT_OFS + 20, 0); cmp("add2", w16(sat(op[3] + op[4] - op[5])), rv);
        end
        apb(1, `SFB_IN_SEL_OFS + 24, 11); apb(1, `SFB_ADD_OP_OFS + 8, 32'h1234);
        apb(0, `SFB_ADD_OP_OFS + 8, 0); cmp("op3_view", w16(src[3]), rv);
        apb(0, `SFB_ADD_OP_OFS, 0); cmp("op1_const", w16(op[0]), rv);
        step();
        apb(0, `SFB_OUT_OFS + 16, 0); cmp("add1_routed", w16(sat(op[0] + op[1] - s[3])), rv);
        $display("adder test done");
        // Lag filter fed by adder 2 held at a constant.
        apb(1, `SFB_ADD_OP_OFS + 16, 0); apb(1, `SFB_ADD_OP_OFS + 20, 0); apb(1, `SFB_IN_SEL_OFS + 12, 6);
        apb(1, `SFB_LAG_TC_OFS, 1); step(); step();
        apb(0, `SFB_LAG_IN_OFS, 0); cmp("lag_in", w16(op[3]), rv);
        apb(0, `SFB_OUT_OFS + 12, 0); cmp("lag_tc1", w16(op[3]), rv);
        apb(1, `SFB_ADD_OP_OFS + 12, 32'h1555); apb(1, `SFB_LAG_TC_OFS, 4);
        repeat (60) step();
        apb(0, `SFB_OUT_OFS + 12, 0); cmp("lag_settle", 1, (rv[15:0] >= 16'h1554 && rv[15:0] <= 16'h1556));
        apb(1, `SFB_LAG_TC_OFS, 0); apb(0, `SFB_LAG_TC_OFS, 0); cmp("tc_min", 32'd1, rv);
        apb(1, `SFB_LAG_TC_OFS, 6000); apb(0, `SFB_LAG_TC_OFS, 0); cmp("tc_max", 32'd5000, rv);
        $display("lag test done");
        // Square wave: levels alternate, each held for three ticks.
        apb(1, `SFB_SQ_HI_OFS, 32'h2000); apb(1, `SFB_SQ_LO_OFS, 32'he000); apb(1, `SFB_SQ_TIME_OFS, 3);
        prv = -1; run = 0; nch = 0;
        for (int n = 0; n < 14; n++) begin
            step();
            apb(0, `SFB_OUT_OFS + 24, 0);
            cmp("sq_level", 1, (rv === 32'h2000 || rv === 32'he000));
            if (n > 0 && int'(rv) != prv) begin
                if (nch > 0) cmp("sq_run", 3, run);
                nch++; run = 1;
            end else run++;
            prv = int'(rv);
        end
        cmp("sq_toggles", 1, (nch >= 3));
        $display("square test done");
        // Unmapped read, save request, and freeze with ce low.
        apb(0, 12'hffc, 0); cmp("unmapped", 32'h1, {rv, re} == 33'h1);
        apb(1, `SFB_SAVE_OFS, 1); repeat (3) @(posedge pclk); cmp("save", 1, seen_save);
        t0 = tgt; ce <= 1'b0; step(); cmp("freeze", {16'h0, t0[0]}, {16'h0, tgt[0]}); ce <= 1'b1;
        $display("misc test done");
        finish_test();
    end
endmodule
